// ---- inc/pmt_pkg.sv ----
// constants and types of the program memory and table read unit
package pmt_pkg;
	// ***********************************************************
	// program store geometry
	// ***********************************************************
	localparam int PC_W = 12;
	localparam int WORD_W = 16;
	localparam int MEM_DEPTH = 4096;
	localparam int PAGE_W = 8;
	localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
	localparam logic [3:0] LAST_PAGE = 4'hF;
	// high byte bits backed by a real word bit (all of them here)
	localparam logic [7:0] TABLE_HIGH_BYTE_HOLDER_IMPL_MASK = 8'hFF;
	localparam logic [7:0] TABLE_HIGH_BYTE_HOLDER_RESET = 8'h00;

	// ***********************************************************
	// data eeprom reached over the serial link
	// ***********************************************************
	localparam int EE_AW = 6;
	localparam int EE_DEPTH = 64;

	// ***********************************************************
	// timing
	// ***********************************************************
	localparam logic [1:0] ICYC_LAST = 2'h3;

	// ***********************************************************
	// serial frame: op, target, 12 address bits, 16 data bits
	// ***********************************************************
	localparam logic [3:0] HDR_LAST_BIT = 4'hD;
	localparam logic [3:0] DATA_LAST_BIT = 4'hF;
	localparam int HDR_OP_BIT = 13;
	localparam int HDR_TGT_BIT = 12;

	typedef enum logic [1:0] {
		PMT_TBL_FULL = 2'b00,
		PMT_TBL_PAGE = 2'b01,
		PMT_TBL_LAST = 2'b10
	} pmt_tbl_kind_t;

	typedef struct packed {
		logic valid;
		pmt_tbl_kind_t kind;
		logic [7:0] operand;
	} pmt_tbl_req_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] data;
	} pmt_dm_wr_t;

	typedef enum logic [1:0] {
		PMT_TR_IDLE = 2'b00,
		PMT_TR_FIRST = 2'b01,
		PMT_TR_SECOND = 2'b10
	} pmt_tr_state_t;

	typedef enum logic [1:0] {
		PMT_SE_HDR = 2'b00,
		PMT_SE_WDATA = 2'b01,
		PMT_SE_RDATA = 2'b10
	} pmt_se_state_t;
endpackage

// ---- design/pmt_program_memory.sv ----
// program store, fetch, table reads and the serial programming port
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - 4K by 16-bit program store, fetched at the program counter.
// - table data readable anywhere, addressed by table pointer, not counter.
// - any reset loads counter with 000H and fetching starts there.
// - full table address is high pointer above low pointer.
// - table read writes word low byte to operand data location.
// - same table read loads word high byte into holding register.
// - holding register bits with no word bit read zero.
// - holding register read-only; only table reads change it.
// - page variant takes pointer relative to current page start.
// - every table read takes two instruction cycles.
// - program store and eeprom written and read back serially.
// - one bidirectional data pin, clocked by programmer-driven clock.
// - programming takes over port A bits 0 and 2.
// - debug data pin bidirectional, debug clock pin input only.
// - emulation variant leaves other functions on debug pins inert.
// - debug pins still serve as programming data and clock.
// - a page is 256 consecutive words for page-relative reads.
// - counter is 12 bits, 4-bit high part, 8-bit low part.

module pmt_program_memory (
	input wire logic clk,
	input wire logic rst,
	// core side
	input wire logic jump,
	input wire logic [11:0] jump_addr,
	input wire logic [7:0] table_pointer_low,
	input wire logic [7:0] table_pointer_high,
	input wire pmt_pkg::pmt_tbl_req_t tbl_req,
	output logic tbl_busy,
	output logic instr_cycle,
	output logic fetch_hold,
	output logic [11:0] pc,
	output logic [15:0] instr,
	output var pmt_pkg::pmt_dm_wr_t dm_wr,
	output logic [7:0] table_high_byte_holder,
	// mode inputs
	input wire logic program_mode_request,
	input wire logic emulation_strap,
	output logic emulation_mode,
	// general purpose side of the shared pins
	input wire logic gpio_bit_zero_out,
	input wire logic gpio_bit_zero_oe,
	input wire logic gpio_bit_two_out,
	input wire logic gpio_bit_two_oe,
	output logic gpio_bit_zero_in,
	output logic gpio_bit_two_in,
	// shared pins: data and clock of programming or debug
	input wire logic port_a_bit_zero_in,
	output logic port_a_bit_zero_out,
	output logic port_a_bit_zero_oe,
	input wire logic port_a_bit_two_in,
	output logic port_a_bit_two_out,
	output logic port_a_bit_two_oe
);
	// ***********************************************************
	// storage
	// ***********************************************************
	logic [15:0] mem [0:pmt_pkg::MEM_DEPTH-1];
	logic [7:0] eeprom [0:pmt_pkg::EE_DEPTH-1];

	// ***********************************************************
	// declarations
	// ***********************************************************
	logic [1:0] div;
	logic prog_s1;
	logic prog_s2;
	logic strap_taken;
	logic link_active;
	logic sck_s1;
	logic sck_s2;
	logic sck_s3;
	logic sda_s1;
	logic sda_s2;
	logic sck_rise;
	logic sck_fall;
	pmt_pkg::pmt_tr_state_t tr_state;
	logic [11:0] tbl_addr;
	logic [7:0] tbl_operand;
	pmt_pkg::pmt_se_state_t se_state;
	logic [3:0] bit_cnt;
	logic [13:0] hdr;
	logic [13:0] next_hdr;
	logic [15:0] shreg;
	logic [15:0] next_shreg;
	logic se_out_bit;
	logic se_drive;
	logic pm_we;
	logic ee_we;
	logic [11:0] wr_addr;
	logic [15:0] wr_data;

	// ***********************************************************
	// helper functions
	// ***********************************************************
	// table address by read variant
	function automatic logic [11:0] table_address(
		input pmt_pkg::pmt_tbl_kind_t kind,
		input logic [3:0] page,
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [11:0] a;
		a = {hi[3:0], lo};
		unique case (kind)
			pmt_pkg::PMT_TBL_FULL: a = {hi[3:0], lo};
			pmt_pkg::PMT_TBL_PAGE: a = {page, lo};
			pmt_pkg::PMT_TBL_LAST: a = {pmt_pkg::LAST_PAGE, lo};
			default: a = {hi[3:0], lo};
		endcase
		return a;
	endfunction

	// word that a serial read returns from either store
	function automatic logic [15:0] serial_word(
		input logic to_eeprom,
		input logic [15:0] pm_word,
		input logic [7:0] ee_byte
	);
		return to_eeprom ? {8'h00, ee_byte} : pm_word;
	endfunction

	// ***********************************************************
	// instruction cycle divider
	// ***********************************************************
	// one enable pulse per four system clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
		end
	end

	assign instr_cycle = (div == pmt_pkg::ICYC_LAST);

	// ***********************************************************
	// mode capture and synchronisers
	// ***********************************************************
	// programming request is a pin, so two stages first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prog_s1 <= 1'b0;
			prog_s2 <= 1'b0;
		end else begin
			prog_s1 <= program_mode_request;
			prog_s2 <= prog_s1;
		end
	end

	// strap caught once, after reset releases
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			strap_taken <= 1'b0;
			emulation_mode <= 1'b0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			emulation_mode <= emulation_strap;
		end
	end

	assign link_active = prog_s2 | emulation_mode;

	// link clock and data pins; third clock stage finds edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			sda_s1 <= 1'b0;
			sda_s2 <= 1'b0;
		end else begin
			sck_s1 <= port_a_bit_two_in;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			sda_s1 <= port_a_bit_zero_in;
			sda_s2 <= sda_s1;
		end
	end

	assign sck_rise = sck_s2 & ~sck_s3;
	assign sck_fall = ~sck_s2 & sck_s3;

	// ***********************************************************
	// instruction fetch
	// ***********************************************************
	// the store port is lent to the table access in its second cycle
	assign fetch_hold = prog_s2 | (tr_state == pmt_pkg::PMT_TR_SECOND);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pc <= pmt_pkg::RESET_VECTOR;
			instr <= 16'h0000;
		end else if (instr_cycle && !fetch_hold) begin
			instr <= mem[pc];
			pc <= jump ? jump_addr : pc + 12'h001;
		end
	end

	// ***********************************************************
	// table read sequencer
	// ***********************************************************
	// request seen on a cycle boundary, result after two cycles
	assign tbl_busy = (tr_state != pmt_pkg::PMT_TR_IDLE) | prog_s2;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tr_state <= pmt_pkg::PMT_TR_IDLE;
			tbl_addr <= 12'h000;
			tbl_operand <= 8'h00;
		end else if (instr_cycle) begin
			unique case (tr_state)
				pmt_pkg::PMT_TR_IDLE: begin
					if (tbl_req.valid && !prog_s2) begin
						tr_state <= pmt_pkg::PMT_TR_FIRST;
						tbl_operand <= tbl_req.operand;
						tbl_addr <= table_address(tbl_req.kind,
							pc[11:8], table_pointer_high,
							table_pointer_low);
					end
				end
				pmt_pkg::PMT_TR_FIRST: begin
					tr_state <= pmt_pkg::PMT_TR_SECOND;
				end
				pmt_pkg::PMT_TR_SECOND: begin
					tr_state <= pmt_pkg::PMT_TR_IDLE;
				end
				default: begin
					tr_state <= pmt_pkg::PMT_TR_IDLE;
				end
			endcase
		end
	end

	// result lands as the second cycle closes; no software write path
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dm_wr <= '0;
			table_high_byte_holder <= pmt_pkg::TABLE_HIGH_BYTE_HOLDER_RESET;
		end else begin
			dm_wr.wr <= 1'b0;
			if (instr_cycle && tr_state == pmt_pkg::PMT_TR_SECOND) begin
				dm_wr.wr <= 1'b1;
				dm_wr.addr <= tbl_operand;
				dm_wr.data <= mem[tbl_addr][7:0];
				table_high_byte_holder <= mem[tbl_addr][15:8]
					& pmt_pkg::TABLE_HIGH_BYTE_HOLDER_IMPL_MASK;
			end
		end
	end

	// ***********************************************************
	// serial programming and debug engine
	// ***********************************************************
	assign next_hdr = {hdr[12:0], sda_s2};
	assign next_shreg = {shreg[14:0], sda_s2};

	// bits are sampled on rising link clock, driven after falling
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			se_state <= pmt_pkg::PMT_SE_HDR;
			bit_cnt <= 4'h0;
			hdr <= 14'h0000;
			shreg <= 16'h0000;
			se_out_bit <= 1'b0;
			se_drive <= 1'b0;
			pm_we <= 1'b0;
			ee_we <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 16'h0000;
		end else if (!link_active) begin
			// dropping the mode aborts any partial frame
			se_state <= pmt_pkg::PMT_SE_HDR;
			bit_cnt <= 4'h0;
			se_drive <= 1'b0;
			pm_we <= 1'b0;
			ee_we <= 1'b0;
		end else begin
			pm_we <= 1'b0;
			ee_we <= 1'b0;
			unique case (se_state)
				pmt_pkg::PMT_SE_HDR: begin
					if (sck_rise) begin
						hdr <= next_hdr;
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == pmt_pkg::HDR_LAST_BIT) begin
							bit_cnt <= 4'h0;
							wr_addr <= next_hdr[11:0];
							if (next_hdr[pmt_pkg::HDR_OP_BIT]) begin
								se_state <= pmt_pkg::PMT_SE_RDATA;
								shreg <= serial_word(
									next_hdr[pmt_pkg::HDR_TGT_BIT],
									mem[next_hdr[11:0]],
									eeprom[next_hdr[5:0]]);
							end else begin
								se_state <= pmt_pkg::PMT_SE_WDATA;
							end
						end
					end
				end
				pmt_pkg::PMT_SE_WDATA: begin
					if (sck_rise) begin
						shreg <= next_shreg;
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == pmt_pkg::DATA_LAST_BIT) begin
							bit_cnt <= 4'h0;
							se_state <= pmt_pkg::PMT_SE_HDR;
							wr_data <= next_shreg;
							pm_we <= ~hdr[pmt_pkg::HDR_TGT_BIT];
							ee_we <= hdr[pmt_pkg::HDR_TGT_BIT];
						end
					end
				end
				pmt_pkg::PMT_SE_RDATA: begin
					if (sck_fall) begin
						se_drive <= 1'b1;
						se_out_bit <= shreg[15];
						shreg <= {shreg[14:0], 1'b0};
					end
					if (sck_rise) begin
						bit_cnt <= bit_cnt + 4'h1;
						if (bit_cnt == pmt_pkg::DATA_LAST_BIT) begin
							bit_cnt <= 4'h0;
							se_state <= pmt_pkg::PMT_SE_HDR;
							se_drive <= 1'b0;
						end
					end
				end
				default: begin
					se_state <= pmt_pkg::PMT_SE_HDR;
				end
			endcase
		end
	end

	// ***********************************************************
	// store writes
	// ***********************************************************
	// flop arrays carry no reset; contents are what was programmed
	always_ff @(posedge clk) begin
		if (pm_we) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (ee_we) begin
			eeprom[wr_addr[pmt_pkg::EE_AW-1:0]] <= wr_data[7:0];
		end
	end

	// ***********************************************************
	// shared pin multiplexing
	// ***********************************************************
	// link owns both pins; clock pin is never driven, gpio goes quiet
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			port_a_bit_zero_out <= 1'b0;
			port_a_bit_zero_oe <= 1'b0;
			port_a_bit_two_out <= 1'b0;
			port_a_bit_two_oe <= 1'b0;
			gpio_bit_zero_in <= 1'b0;
			gpio_bit_two_in <= 1'b0;
		end else if (link_active) begin
			port_a_bit_zero_out <= se_out_bit;
			port_a_bit_zero_oe <= se_drive;
			port_a_bit_two_out <= 1'b0;
			port_a_bit_two_oe <= 1'b0;
			gpio_bit_zero_in <= 1'b0;
			gpio_bit_two_in <= 1'b0;
		end else begin
			port_a_bit_zero_out <= gpio_bit_zero_out;
			port_a_bit_zero_oe <= gpio_bit_zero_oe;
			port_a_bit_two_out <= gpio_bit_two_out;
			port_a_bit_two_oe <= gpio_bit_two_oe;
			gpio_bit_zero_in <= sda_s2;
			gpio_bit_two_in <= sck_s2;
		end
	end
endmodule
`default_nettype wire

// ---- test/pmt_program_memory_assertions.sv ----
// assertion checker for the program memory and table read unit
`timescale 1ns/100ps
`default_nettype none
module pmt_program_memory_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic jump,
	input wire logic [11:0] jump_addr,
	input wire pmt_pkg::pmt_tbl_req_t tbl_req,
	input wire logic tbl_busy,
	input wire logic instr_cycle,
	input wire logic fetch_hold,
	input wire logic [11:0] pc,
	input wire pmt_pkg::pmt_dm_wr_t dm_wr,
	input wire logic [7:0] table_high_byte_holder,
	input wire logic port_a_bit_two_oe
);
	// ***************************************
	// table read and fetch timing
	// ***************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// request accepted at an instruction edge
	sequence s_take;
		instr_cycle && tbl_req.valid && !tbl_busy;
	endsequence
	// fetch allowed at this edge
	sequence s_fetch;
		instr_cycle && !fetch_hold;
	endsequence
	a_answer_on_time: assert property (s_take |=> !dm_wr.wr [*8] ##1 dm_wr.wr)
		else $error("table result not after two instruction cycles");
	a_busy_span: assert property (s_take |=> tbl_busy [*8] ##1 !tbl_busy)
		else $error("busy span of table read wrong");
	a_hold_second_cycle: assert property (
		s_take |=> !fetch_hold [*4] ##1 fetch_hold [*4] ##1 !fetch_hold)
		else $error("fetch hold not in second table cycle");
	a_pc_frozen: assert property (fetch_hold && instr_cycle |=> $stable(pc))
		else $error("counter moved while fetch held");
	a_pc_step: assert property (s_fetch ##0 !jump |=> pc == $past(pc) + 12'h001)
		else $error("counter did not step by one");
	a_jump_load: assert property (s_fetch ##0 jump |=> pc == $past(jump_addr))
		else $error("counter did not take jump target");
	a_reset_vector: assert property ($fell(rst) |-> pc == pmt_pkg::RESET_VECTOR)
		else $error("counter not at reset vector");
	a_holder_source: assert property ($changed(table_high_byte_holder) |-> dm_wr.wr)
		else $error("holder changed without table read");
	a_clock_pin_input: assert property (!port_a_bit_two_oe)
		else $error("link clock pin driven");
endmodule
bind pmt_program_memory pmt_program_memory_checker i_pmt_program_memory_checker (
	.clk(clk), .rst(rst), .jump(jump), .jump_addr(jump_addr),
	.tbl_req(tbl_req), .tbl_busy(tbl_busy), .instr_cycle(instr_cycle),
	.fetch_hold(fetch_hold), .pc(pc), .dm_wr(dm_wr),
	.table_high_byte_holder(table_high_byte_holder),
	.port_a_bit_two_oe(port_a_bit_two_oe));
`default_nettype wire

// ---- test/pmt_link_model.sv ----
// behavioural serial programming tool on the shared pins
`timescale 1ns/100ps
`default_nettype none
module pmt_link_model (
	input wire logic dut_out,
	input wire logic dut_oe,
	output logic data_line,
	output logic sck
);
	logic drv_en = 1'b0;
	logic drv_val = 1'b0;
	// ***************************************
	// pin resolution and framing
	// ***************************************
	// pulled up when released, so no stale level lingers
	assign data_line = dut_oe ? dut_out : (drv_en ? drv_val : 1'b1);
	// clock stands low between frames
	initial sck = 1'b0;
	// one frame: 14 header bits then 16 data bits, msb first
	task automatic frame(input logic [13:0] hdr, input logic [15:0] wd,
			output logic [15:0] rd);
		logic [29:0] f;
		f = {hdr, wd};
		#3;
		for (int i = 29; i >= 0; i--) begin
			// let go of the data pin while the device answers
			drv_en = (i >= 16) || !hdr[13];
			drv_val = f[i];
			#80 sck = 1'b1;
			if (i < 16)
				rd[i] = data_line;
			#80 sck = 1'b0;
		end
		drv_en = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- test/pmt_program_memory_bench.sv ----
// self-checking bench for the program memory and table read unit
`timescale 1ns/100ps
`default_nettype none
module pmt_program_memory_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic jump = 1'b0;
	logic [11:0] jump_addr = 12'h000;
	logic [7:0] tp_lo = 8'h00;
	logic [7:0] tp_hi = 8'h00;
	pmt_pkg::pmt_tbl_req_t tbl_req = '0;
	logic prog_req = 1'b0;
	logic tbl_busy, instr_cycle, fetch_hold, pa0_out, pa0_oe, pa0_line, sck;
	logic [11:0] pc;
	logic [15:0] instr;
	pmt_pkg::pmt_dm_wr_t dm_wr;
	logic [7:0] holder;
	logic [31:0] rnd = 32'hBB3E;
	logic [23:0] expq[$];
	logic [11:0] addr[4];
	logic [15:0] word[4];
	logic [15:0] rd;
	logic [7:0] hi;
	int err_count = 0;
	int checks = 0;

	// ***************************************
	// clock, design and partner
	// ***************************************
	always #4 clk = ~clk;
	pmt_program_memory i_pmt_program_memory (.clk(clk), .rst(rst),
		.jump(jump), .jump_addr(jump_addr), .table_pointer_low(tp_lo),
		.table_pointer_high(tp_hi), .tbl_req(tbl_req), .tbl_busy(tbl_busy),
		.instr_cycle(instr_cycle), .fetch_hold(fetch_hold), .pc(pc),
		.instr(instr), .dm_wr(dm_wr), .table_high_byte_holder(holder),
		.program_mode_request(prog_req), .emulation_strap(1'b0),
		.emulation_mode(), .gpio_bit_zero_out(1'b0), .gpio_bit_zero_oe(1'b0),
		.gpio_bit_two_out(1'b0), .gpio_bit_two_oe(1'b0), .gpio_bit_zero_in(),
		.gpio_bit_two_in(), .port_a_bit_zero_in(pa0_line),
		.port_a_bit_zero_out(pa0_out), .port_a_bit_zero_oe(pa0_oe),
		.port_a_bit_two_in(sck), .port_a_bit_two_out(),
		.port_a_bit_two_oe());
	pmt_link_model i_pmt_link_model (.dut_out(pa0_out), .dut_oe(pa0_oe),
		.data_line(pa0_line), .sck(sck));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bounded wait for an instruction edge, or for the read to finish
	task automatic wait_for(input bit idle);
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if (idle ? (tbl_busy === 1'b0) : (instr_cycle === 1'b1))
				return;
		end
		err_count++;
		give_verdict();
	endtask
	// one table read; a refused request stands during the busy span
	task automatic tbl_read(input logic [1:0] kind, input logic [7:0] h,
			input logic [7:0] op);
		wait_for(1'b0);
		tp_hi = h;
		tbl_req = {1'b1, kind, op};
		@(posedge clk);
		@(negedge clk);
		tp_lo = ~tp_lo;
		tp_hi = ~h;
		tbl_req.operand = ~op;
		repeat (4) @(negedge clk);
		tbl_req.valid = 1'b0;
		tp_lo = ~tp_lo;
		// never start a read before the last one ends
		wait_for(1'b1);
	endtask

	// results pop the oldest note when the write pulse appears
	always @(negedge clk)
		if (dm_wr.wr === 1'b1) begin
			if (expq.size() == 0)
				check(32'h1, 32'h0);
			else
				check({dm_wr.addr, dm_wr.data, holder}, expq.pop_front());
		end
	// hang guard
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		give_verdict();
	end

	// ***************************************
	// scenarios
	// ***************************************
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		prog_req = 1'b1;
		repeat (8) @(negedge clk);
		rnd = lfsr(rnd);
		tp_lo = rnd[15:8] | 8'h80;
		hi = {rnd[7:4], 3'h0, rnd[0]};
		addr[0] = pmt_pkg::RESET_VECTOR;
		addr[1] = {hi[3:0], tp_lo};
		addr[2] = {4'h3, tp_lo};
		addr[3] = {pmt_pkg::LAST_PAGE, tp_lo};
		for (int k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			word[k] = rnd[15:0];
			i_pmt_link_model.frame({2'h0, addr[k]}, word[k], rd);
		end
		for (int k = 0; k < 4; k++) begin
			i_pmt_link_model.frame({2'h2, addr[k]}, 16'h0000, rd);
			check(rd, word[k]);
		end
		// top eeprom byte; reads back with an empty high byte
		i_pmt_link_model.frame(14'h103F, {8'h00, rnd[23:16]}, rd);
		i_pmt_link_model.frame(14'h303F, 16'h0000, rd);
		check(rd, {8'h00, rnd[23:16]});
		@(negedge clk);
		prog_req = 1'b0;
		$display("test serial link done");
		@(negedge clk);
		rst = 1'b1;
		#1;
		check(pc, 12'h000);
		repeat (2) @(negedge clk);
		rst = 1'b0;
		wait_for(1'b0);
		@(negedge clk);
		check(instr, word[0]);
		check(pc, 12'h001);
		$display("test reset vector done");
		// park the counter in page 3 for the page-relative read
		jump_addr = 12'h3F0;
		jump = 1'b1;
		wait_for(1'b0);
		wait_for(1'b0);
		for (int k = 1; k < 4; k++) begin
			rnd = lfsr(rnd);
			expq.push_back({rnd[31:24], word[k][7:0],
				word[k][15:8] & pmt_pkg::TABLE_HIGH_BYTE_HOLDER_IMPL_MASK});
			tbl_read(2'(k - 1), (k == 1) ? hi : rnd[7:0], rnd[31:24]);
		end
		wait_for(1'b1);
		check(expq.size(), 32'h0);
		$display("test table reads done");
		give_verdict();
	end
endmodule
`default_nettype wire
